/* File: sarc_pkg.sv */
package sarc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_CRIT = 8'h08;
  localparam logic [7:0] OFF_CAUSE = 8'h0c;
  localparam logic [7:0] OFF_WDT_LOAD = 8'h10;
  localparam logic [7:0] OFF_WDT_KICK = 8'h14;
  localparam logic [7:0] OFF_CHKPT = 8'h18;
  localparam logic [7:0] OFF_CHKPT_EXP = 8'h1c;
  localparam logic [7:0] OFF_SELFTEST = 8'h20;
  localparam logic [7:0] OFF_ROM_REF = 8'h24;
  localparam logic [7:0] OFF_MMU_PERM = 8'h28;
  localparam logic [7:0] OFF_CTRL = 8'h2c;

  // Alarm event bit positions
  localparam int EV_W = 12;
  localparam int EV_MEM = 0;
  localparam int EV_ROM = 1;
  localparam int EV_NVM_UNC = 2;
  localparam int EV_ROM_SUM = 3;
  localparam int EV_CPU_CMP = 4;
  localparam int EV_SENSOR = 5;
  localparam int EV_ILL_OP = 6;
  localparam int EV_BUS_HS = 7;
  localparam int EV_WDT = 8;
  localparam int EV_CHKPT = 9;
  localparam int EV_CIPHER = 10;
  localparam int EV_MMU = 11;

  // Reset values
  localparam logic [EV_W-1:0] MASK_RST = 12'h000;
  localparam logic [EV_W-1:0] CRIT_RST = 12'hc7f;
  localparam logic [EV_W-1:0] CRIT_FORCED = 12'h070;
  localparam logic [31:0] WDT_LOAD_RST = 32'h000f_ffff;
  localparam logic [31:0] ROM_REF_RST = 32'h0000_0000;
  localparam logic [13:0] MMU_PERM_RST = 14'h0003;
  localparam logic [1:0] CTRL_RST = 2'h2;
  localparam int CTRL_WDT_EN = 0;
  localparam int CTRL_HS_EN = 1;

  // Cycle, word and level counts
  localparam int HS_TIMEOUT = 16;
  localparam int FILL_DEPTH = 64;
  localparam int PRIV_LEVELS = 7;

  typedef enum logic [2:0] {
    SARC_RUN = 3'b001,
    SARC_WIPE = 3'b010,
    SARC_HOLD = 3'b100
  } sarc_state_t;

  typedef struct packed {
    logic valid;
    logic ram_err;
    logic rom_err;
    logic path_err;
  } sarc_mem_chk_t;

  typedef struct packed {
    logic valid;
    logic mbe;
    logic [31:0] flip;
    logic [31:0] data;
  } sarc_nvm_rd_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } sarc_rom_scan_t;

  typedef struct packed {
    logic valid;
    logic [31:0] a;
    logic [31:0] b;
  } sarc_pair_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] level;
  } sarc_mmu_req_t;

endpackage : sarc_pkg

/* File: sarc_alarm_ctrl.sv */
`timescale 1ns/1ns
// Behaviour
// RL1 - Every RAM, ROM, NVM, encryption and translation access is checked; failures flagged.
// RL2 - Single-bit NVM read errors are corrected and returned without an alarm.
// RL3 - A check value over whole ROM is recomputed and compared to reference.
// RL4 - Both processor halves compute the same task; results compared at completion.
// RL5 - Result mismatch is recorded and starts the secure reset sequence.
// RL6 - Any attack sensor halts processing at once and enters security reset.
// RL7 - Security reset returns both cipher coprocessors to reset values immediately.
// RL8 - Security reset overwrites all key registers with default contents.
// RL9 - Security reset fills coprocessor memories with random source values.
// RL10 - Illegal opcode detection triggers a security reset.
// RL11 - Bus handshakes are monitored; incomplete or stray handshake raises an alarm.
// RL12 - Watchdog timer and program-flow checkpoint register are provided.
// RL13 - Cipher results are checked by backward calculation; mismatch flagged.
// RL14 - Software may start an alarm-source self-test at any time.
// RL15 - Uncorrectable errors alarm; critical ones force security alarm and reset.
// RL16 - Reset during NVM programming requests rollback and a power-on restart.
// RL17 - Seven privilege levels each get software-set read and write rights.
// RL18 - Any single critical source starts reset, held until clearing finishes.
// RL19 - Cause of last security reset is latched, survives it, readable.
module sarc_alarm_ctrl #(
  parameter int SENSORS = 4,
  parameter int HS_LIMIT = sarc_pkg::HS_TIMEOUT,
  parameter int FILL_WORDS = sarc_pkg::FILL_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sarc_pkg::sarc_mem_chk_t mem_chk,
  input wire sarc_pkg::sarc_nvm_rd_t nvm_rd,
  output logic [31:0] nvm_fix_data,
  output logic nvm_fix_valid,
  input wire sarc_pkg::sarc_rom_scan_t rom_scan,
  input wire sarc_pkg::sarc_pair_t cpu_res,
  input wire logic [SENSORS-1:0] sensor_alarm_n,
  input wire logic illegal_op,
  input wire logic bus_req,
  input wire logic bus_ack,
  input wire sarc_pkg::sarc_pair_t cipher_chk,
  input wire sarc_pkg::sarc_mmu_req_t mmu_req,
  output logic mmu_deny,
  input wire logic nvm_prog_busy,
  output logic nvm_prog_abort,
  output logic por_req,
  input wire logic [31:0] rnd_data,
  output logic sec_rst,
  output logic key_clr,
  output logic fill_we,
  output logic [$clog2(FILL_WORDS)-1:0] fill_addr,
  output logic [31:0] fill_data,
  output logic irq
);

  localparam int AW = $clog2(FILL_WORDS);
  localparam logic [AW-1:0] FILL_LAST = AW'(FILL_WORDS - 1);
  localparam logic [7:0] HS_LAST = 8'(HS_LIMIT - 1);

  // MMU rights: bit 2L reads, bit 2L+1 writes
  function automatic logic perm_ok(input logic [13:0] perm,
                                   input sarc_pkg::sarc_mmu_req_t r);
    logic ok;
    ok = 1'b0;
    if (r.level < 3'(sarc_pkg::PRIV_LEVELS)) begin
      ok = perm[{r.level, r.write}];
    end
    return ok;
  endfunction : perm_ok

  sarc_pkg::sarc_state_t state_reg;
  logic [sarc_pkg::EV_W-1:0] status_reg;
  logic [sarc_pkg::EV_W-1:0] mask_reg;
  logic [sarc_pkg::EV_W-1:0] crit_reg;
  logic [sarc_pkg::EV_W-1:0] cause_reg;
  logic [sarc_pkg::EV_W-1:0] st_req_reg;
  logic [sarc_pkg::EV_W-1:0] st_seen_reg;
  logic [sarc_pkg::EV_W-1:0] inject_reg;
  logic st_done_reg;
  logic [31:0] wdt_load_reg;
  logic [31:0] wdt_cnt_reg;
  logic [31:0] chk_sig_reg;
  logic [31:0] rom_ref_reg;
  logic [31:0] rom_acc_reg;
  logic [13:0] mmu_perm_reg;
  logic [1:0] ctrl_reg;
  logic [7:0] hs_cnt_reg;
  logic [SENSORS-1:0] s1_reg;
  logic [SENSORS-1:0] s2_reg;
  logic [SENSORS-1:0] s3_reg;
  logic [SENSORS-1:0] sens_reg;
  logic prog_torn_reg;
  logic [sarc_pkg::EV_W-1:0] ev;
  logic [sarc_pkg::EV_W-1:0] ev_all;
  logic [sarc_pkg::EV_W-1:0] crit;
  logic [31:0] rom_next;
  logic wr_en;
  logic rd_hit;
  logic [31:0] rd_val;
  logic nvm_multi;
  logic wdt_kick;
  logic chk_exp_wr;

  // APB access decode; write takes effect at the completing edge
  assign wr_en = psel & penable & pready & pwrite;
  assign wdt_kick = wr_en & (paddr == sarc_pkg::OFF_WDT_KICK);
  assign chk_exp_wr = wr_en & (paddr == sarc_pkg::OFF_CHKPT_EXP);
  assign nvm_multi = nvm_rd.mbe | |(nvm_rd.flip & (nvm_rd.flip - 32'h1));
  assign rom_next = {rom_acc_reg[30:0], rom_acc_reg[31]} ^ rom_scan.data;

  // Event collection from all alarm sources
  always_comb begin
    ev = '0;
    ev[sarc_pkg::EV_MEM] = mem_chk.valid &
                           (mem_chk.ram_err | mem_chk.path_err); // RL1
    ev[sarc_pkg::EV_ROM] = mem_chk.valid & mem_chk.rom_err; // RL1
    ev[sarc_pkg::EV_NVM_UNC] = nvm_rd.valid & nvm_multi; // RL15
    ev[sarc_pkg::EV_ROM_SUM] = rom_scan.valid & rom_scan.last &
                               (rom_next != rom_ref_reg); // RL3
    ev[sarc_pkg::EV_CPU_CMP] = cpu_res.valid &
                               (cpu_res.a != cpu_res.b); // RL4
    ev[sarc_pkg::EV_SENSOR] = |sens_reg; // RL6
    ev[sarc_pkg::EV_ILL_OP] = illegal_op; // RL10
    ev[sarc_pkg::EV_BUS_HS] = ctrl_reg[sarc_pkg::CTRL_HS_EN] &
      ((bus_req & ~bus_ack & hs_cnt_reg == HS_LAST) |
       (bus_ack & ~bus_req)); // RL11
    ev[sarc_pkg::EV_WDT] = ctrl_reg[sarc_pkg::CTRL_WDT_EN] &
                           (wdt_cnt_reg == 32'h0) & ~wdt_kick; // RL12
    ev[sarc_pkg::EV_CHKPT] = chk_exp_wr & (pwdata != chk_sig_reg); // RL12
    ev[sarc_pkg::EV_CIPHER] = cipher_chk.valid &
                              (cipher_chk.a != cipher_chk.b); // RL13
    ev[sarc_pkg::EV_MMU] = mmu_req.valid &
                           ~perm_ok(mmu_perm_reg, mmu_req); // RL17
  end

  // Self-test injects reach status and the self-test result only; critical path sees real events
  assign ev_all = ev | inject_reg; // RL14
  assign crit = ev & (crit_reg | sarc_pkg::CRIT_FORCED); // RL15 RL18

  // Attack sensor synchroniser, change accepted when stages 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
      sens_reg <= '0;
    end else if (clk_en) begin
      s1_reg <= sensor_alarm_n;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < SENSORS; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          sens_reg[i] <= ~s3_reg[i];
        end
      end
    end
  end

  // APB slave response, one wait-free access phase
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    case (paddr)
      sarc_pkg::OFF_STATUS: rd_val = 32'(status_reg);
      sarc_pkg::OFF_MASK: rd_val = 32'(mask_reg);
      sarc_pkg::OFF_CRIT: rd_val = 32'(crit_reg);
      sarc_pkg::OFF_CAUSE: rd_val = 32'(cause_reg);
      sarc_pkg::OFF_WDT_LOAD: rd_val = wdt_load_reg;
      sarc_pkg::OFF_WDT_KICK: rd_val = wdt_cnt_reg;
      sarc_pkg::OFF_CHKPT: rd_val = chk_sig_reg;
      sarc_pkg::OFF_CHKPT_EXP: rd_val = 32'h0;
      sarc_pkg::OFF_SELFTEST: rd_val = {st_done_reg, 19'h0, st_seen_reg};
      sarc_pkg::OFF_ROM_REF: rd_val = rom_ref_reg;
      sarc_pkg::OFF_MMU_PERM: rd_val = 32'(mmu_perm_reg);
      sarc_pkg::OFF_CTRL: rd_val = 32'(ctrl_reg);
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (clk_en) begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~rd_hit;
      prdata <= (psel & ~penable & ~pwrite) ? rd_val : 32'h0;
    end
  end

  // Software configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= sarc_pkg::MASK_RST;
      crit_reg <= sarc_pkg::CRIT_RST;
      wdt_load_reg <= sarc_pkg::WDT_LOAD_RST;
      rom_ref_reg <= sarc_pkg::ROM_REF_RST;
      mmu_perm_reg <= sarc_pkg::MMU_PERM_RST;
      ctrl_reg <= sarc_pkg::CTRL_RST;
    end else if (clk_en && wr_en) begin
      case (paddr)
        sarc_pkg::OFF_MASK: mask_reg <= pwdata[sarc_pkg::EV_W-1:0];
        sarc_pkg::OFF_CRIT: crit_reg <= pwdata[sarc_pkg::EV_W-1:0]; // RL15
        sarc_pkg::OFF_WDT_LOAD: wdt_load_reg <= pwdata;
        sarc_pkg::OFF_ROM_REF: rom_ref_reg <= pwdata; // RL3
        sarc_pkg::OFF_MMU_PERM: mmu_perm_reg <= pwdata[13:0]; // RL17
        sarc_pkg::OFF_CTRL: ctrl_reg <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
      irq <= 1'b0;
    end else if (clk_en) begin
      if (wr_en && paddr == sarc_pkg::OFF_STATUS) begin
        status_reg <= (status_reg & ~pwdata[sarc_pkg::EV_W-1:0]) | ev_all;
      end else begin
        status_reg <= status_reg | ev_all;
      end
      irq <= |(status_reg & mask_reg);
    end
  end

  // Self-test: a write injects the chosen sources for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inject_reg <= '0;
      st_req_reg <= '0;
      st_seen_reg <= '0;
      st_done_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_en && paddr == sarc_pkg::OFF_SELFTEST) begin
        inject_reg <= pwdata[sarc_pkg::EV_W-1:0]; // RL14
        st_req_reg <= pwdata[sarc_pkg::EV_W-1:0];
        st_seen_reg <= '0;
        st_done_reg <= 1'b0;
      end else begin
        inject_reg <= '0;
        if (|inject_reg) begin
          st_seen_reg <= ev_all & st_req_reg; // RL14
          st_done_reg <= 1'b1;
        end
      end
    end
  end

  // NVM read correction of a single flipped bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_fix_data <= 32'h0;
      nvm_fix_valid <= 1'b0;
    end else if (clk_en) begin
      nvm_fix_valid <= nvm_rd.valid & ~nvm_multi;
      nvm_fix_data <= nvm_rd.data ^ nvm_rd.flip; // RL2
    end
  end

  // ROM check value accumulator, restarted after each last word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_acc_reg <= 32'h0;
    end else if (clk_en && rom_scan.valid) begin
      rom_acc_reg <= rom_scan.last ? 32'h0 : rom_next; // RL3
    end
  end

  // Handshake monitor counts cycles a request waits for its ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_cnt_reg <= 8'h0;
    end else if (clk_en) begin
      if (!bus_req || bus_ack || hs_cnt_reg == HS_LAST) begin
        hs_cnt_reg <= 8'h0;
      end else begin
        hs_cnt_reg <= hs_cnt_reg + 8'h1; // RL11
      end
    end
  end

  // Watchdog down-counter, reloaded by a kick or on expiry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt_reg <= sarc_pkg::WDT_LOAD_RST;
    end else if (clk_en) begin
      if (wdt_kick || !ctrl_reg[sarc_pkg::CTRL_WDT_EN] ||
          wdt_cnt_reg == 32'h0) begin
        wdt_cnt_reg <= wdt_load_reg; // RL12
      end else begin
        wdt_cnt_reg <= wdt_cnt_reg - 32'h1;
      end
    end
  end

  // Program-flow signature, folded by each checkpoint write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_sig_reg <= 32'h0;
    end else if (clk_en && wr_en) begin
      if (paddr == sarc_pkg::OFF_CHKPT) begin
        chk_sig_reg <= {chk_sig_reg[30:0], chk_sig_reg[31]} ^ pwdata; // RL12
      end else if (paddr == sarc_pkg::OFF_CHKPT_EXP) begin
        chk_sig_reg <= 32'h0;
      end
    end
  end

  // MMU access verdict
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mmu_deny <= 1'b0;
    end else if (clk_en) begin
      mmu_deny <= ev[sarc_pkg::EV_MMU]; // RL17
    end
  end

  // Cause of last security reset; only the power-on reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_reg <= '0;
    end else if (clk_en && state_reg == sarc_pkg::SARC_RUN && |crit) begin
      cause_reg <= crit; // RL19
    end
  end

  // Security reset sequence: wipe keys, fill memories, then release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= sarc_pkg::SARC_RUN;
      sec_rst <= 1'b0;
      key_clr <= 1'b0;
      fill_we <= 1'b0;
      fill_addr <= '0;
      fill_data <= 32'h0;
    end else if (clk_en) begin
      case (state_reg)
        sarc_pkg::SARC_RUN: begin
          if (|crit) begin
            state_reg <= sarc_pkg::SARC_WIPE; // RL5 RL6 RL10 RL18
            sec_rst <= 1'b1; // RL7
            key_clr <= 1'b1; // RL8
            fill_we <= 1'b1;
            fill_addr <= '0;
            fill_data <= rnd_data; // RL9
          end
        end
        sarc_pkg::SARC_WIPE: begin
          fill_data <= rnd_data; // RL9
          if (fill_addr == FILL_LAST) begin
            state_reg <= sarc_pkg::SARC_HOLD;
            fill_we <= 1'b0;
            key_clr <= 1'b0;
          end else begin
            fill_addr <= fill_addr + AW'(1);
          end
        end
        sarc_pkg::SARC_HOLD: begin
          state_reg <= sarc_pkg::SARC_RUN;
          sec_rst <= 1'b0; // RL18
        end
        default: begin
          state_reg <= sarc_pkg::SARC_RUN;
          sec_rst <= 1'b0;
        end
      endcase
    end
  end

  // Torn NVM programming: roll back and restart through power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_torn_reg <= 1'b0;
      nvm_prog_abort <= 1'b0;
      por_req <= 1'b0;
    end else if (clk_en) begin
      nvm_prog_abort <= 1'b0;
      por_req <= 1'b0;
      if (state_reg == sarc_pkg::SARC_RUN && |crit && nvm_prog_busy) begin
        prog_torn_reg <= 1'b1;
        nvm_prog_abort <= 1'b1; // RL16
      end else if (state_reg == sarc_pkg::SARC_HOLD && prog_torn_reg) begin
        prog_torn_reg <= 1'b0;
        por_req <= 1'b1; // RL16
      end
    end
  end

endmodule : sarc_alarm_ctrl

/* File: sarc_alarm_ctrl_properties.sv */
`timescale 1ns/1ns
module sarc_alarm_ctrl_properties #(
  parameter int SENSORS = 4,
  parameter int FILL_WORDS = sarc_pkg::FILL_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire sarc_pkg::sarc_nvm_rd_t nvm_rd,
  input wire logic [31:0] nvm_fix_data,
  input wire logic nvm_fix_valid,
  input wire sarc_pkg::sarc_pair_t cpu_res,
  input wire logic [SENSORS-1:0] sensor_alarm_n,
  input wire logic illegal_op,
  input wire sarc_pkg::sarc_mmu_req_t mmu_req,
  input wire logic mmu_deny,
  input wire logic nvm_prog_busy,
  input wire logic nvm_prog_abort,
  input wire logic [31:0] rnd_data,
  input wire logic sec_rst,
  input wire logic key_clr,
  input wire logic fill_we,
  input wire logic [$clog2(FILL_WORDS)-1:0] fill_addr,
  input wire logic [31:0] fill_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Counts enabled cycles of one security reset
  logic [7:0] run_len_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_len_reg <= 8'h00;
    end else if (!sec_rst) begin
      run_len_reg <= 8'h00;
    end else if (clk_en) begin
      run_len_reg <= run_len_reg + 8'h01;
    end
  end

  // Reset entry and sequence shape
  property p_illegal;
    illegal_op && clk_en && !sec_rst |=> sec_rst && fill_addr == '0;
  endproperty
  a_illegal: assert property (p_illegal) else $error("no reset on opcode");
  property p_cpu;
    cpu_res.valid && cpu_res.a != cpu_res.b && clk_en && !sec_rst
      |=> sec_rst && key_clr;
  endproperty
  a_cpu: assert property (p_cpu) else $error("no reset on mismatch");
  property p_sensor;
    (!(&sensor_alarm_n) && clk_en)[*3] |-> ##[1:5] sec_rst;
  endproperty
  a_sensor: assert property (p_sensor) else $error("sensor ignored");
  property p_len;
    $fell(sec_rst) |-> run_len_reg == FILL_WORDS + 1;
  endproperty
  a_len: assert property (p_len) else $error("reset length wrong");
  property p_key;
    key_clr |-> sec_rst && fill_we;
  endproperty
  a_key: assert property (p_key) else $error("key clear outside wipe");
  property p_fill_data;
    fill_we && $past(clk_en) |-> fill_data == $past(rnd_data);
  endproperty
  a_fill_data: assert property (p_fill_data) else $error("fill data");
  property p_fill_addr;
    fill_we && $past(fill_we) && $past(clk_en)
      |-> fill_addr == $past(fill_addr) + 1'b1;
  endproperty
  a_fill_addr: assert property (p_fill_addr) else $error("fill step");
  property p_abort;
    nvm_prog_busy && illegal_op && clk_en && !sec_rst |=> nvm_prog_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("no program abort");

  // Side paths: correction and permission
  property p_fix;
    nvm_rd.valid && !nvm_rd.mbe && $onehot(nvm_rd.flip) && clk_en
      |=> nvm_fix_valid
      && nvm_fix_data == ($past(nvm_rd.data) ^ $past(nvm_rd.flip));
  endproperty
  a_fix: assert property (p_fix) else $error("nvm not corrected");
  property p_deny;
    mmu_req.valid && mmu_req.level == 3'h7 && clk_en |=> mmu_deny;
  endproperty
  a_deny: assert property (p_deny) else $error("level 7 granted");

  c_rst: cover property ($rose(sec_rst));
  c_fix: cover property (nvm_fix_valid);
  c_deny: cover property (mmu_deny);
endmodule : sarc_alarm_ctrl_properties

bind sarc_alarm_ctrl sarc_alarm_ctrl_properties #(
  .SENSORS(SENSORS),
  .FILL_WORDS(FILL_WORDS)
) u_props (.pclk, .presetn, .clk_en, .nvm_rd, .nvm_fix_data,
  .nvm_fix_valid, .cpu_res, .sensor_alarm_n, .illegal_op, .mmu_req,
  .mmu_deny, .nvm_prog_busy, .nvm_prog_abort, .rnd_data, .sec_rst,
  .key_clr, .fill_we, .fill_addr, .fill_data);

/* File: sarc_far_model.sv */
`timescale 1ns/1ns
module sarc_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] cmd,
  output sarc_pkg::sarc_mem_chk_t mem_chk,
  output sarc_pkg::sarc_nvm_rd_t nvm_rd,
  output sarc_pkg::sarc_rom_scan_t rom_scan,
  output sarc_pkg::sarc_pair_t cpu_res,
  output sarc_pkg::sarc_pair_t cipher_chk,
  output sarc_pkg::sarc_mmu_req_t mmu_req,
  output logic [3:0] sensor_alarm_n,
  output logic illegal_op,
  output logic bus_req,
  output logic bus_ack,
  output logic nvm_prog_busy,
  output logic [31:0] rnd_data
);
  logic [3:0] cmd_reg;
  logic [3:0] mode_reg;
  logic [3:0] cnt_reg;

  // Random source and command timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rnd_data <= 32'h1357_9bdf;
      cmd_reg <= 4'h0;
      mode_reg <= 4'h0;
      cnt_reg <= 4'h0;
    end else begin
      rnd_data <= {rnd_data[30:0], rnd_data[31] ^ rnd_data[21]};
      cmd_reg <= cmd;
      mode_reg <= (cmd != 4'h0) ? cmd : mode_reg;
      cnt_reg <= (cmd == 4'h3) ? 4'h3 : (cmd == 4'h7) ? 4'h8 :
        (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
    end
  end

  // ROM, CPU and cipher data fields follow the random source; NVM data and flip are fixed values
  assign mem_chk = '{cmd_reg == 4'hb, 1'b1, 1'b0, 1'b0};
  assign nvm_rd = '{cmd_reg == 4'h4 || cmd_reg == 4'ha, cmd_reg == 4'ha,
    32'h0000_0100, 32'h0000_1234};
  assign rom_scan = '{cmd_reg == 4'he, cmd_reg == 4'he, rnd_data};
  assign cpu_res = '{cmd_reg == 4'h2 || cmd_reg == 4'hc, rnd_data,
    (cmd_reg == 4'hc) ? rnd_data : ~rnd_data};
  assign cipher_chk = '{cmd_reg == 4'h9, rnd_data, ~rnd_data};
  assign mmu_req = '{cmd_reg == 4'h5 || cmd_reg == 4'h6, 1'b0,
    (cmd_reg == 4'h5) ? 3'h7 : 3'h0};
  assign sensor_alarm_n = {3'h7, !(mode_reg == 4'h3 && cnt_reg != 4'h0)};
  assign illegal_op = cmd_reg == 4'h1 || cmd_reg == 4'h8;
  assign nvm_prog_busy = cmd_reg == 4'h8;
  // Target answers at once, or stalls eight cycles
  assign bus_req = (mode_reg == 4'h7 && cnt_reg != 4'h0) ||
    cmd_reg == 4'hd;
  assign bus_ack = (mode_reg == 4'h7 && cnt_reg == 4'h1) ||
    cmd_reg == 4'hd;
endmodule : sarc_far_model

/* File: sarc_alarm_ctrl_test.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, ac) begin \
  comparisons++; \
  if ((ac) !== (ex)) begin \
    mismatches++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, ac); \
  end \
end
module sarc_alarm_ctrl_test;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] cmd = '0;
  logic clk_en = 1'h1;
  logic [31:0] prdata, rdv, nvm_fix_data, rnd_data, fill_data;
  logic [3:0] sensor_alarm_n;
  logic pready, pslverr, errv, nvm_fix_valid, illegal_op, bus_req, bus_ack;
  logic mmu_deny, nvm_prog_busy, nvm_prog_abort, por_req, sec_rst, key_clr;
  logic fill_we, irq;
  logic abort_seen = 1'h0;
  logic por_seen = 1'h0;
  logic [1:0] fill_addr;
  sarc_pkg::sarc_mem_chk_t mem_chk;
  sarc_pkg::sarc_nvm_rd_t nvm_rd;
  sarc_pkg::sarc_rom_scan_t rom_scan;
  sarc_pkg::sarc_pair_t cpu_res, cipher_chk;
  sarc_pkg::sarc_mmu_req_t mmu_req;
  int mismatches = 0;
  int comparisons = 0;

  always #10 pclk = ~pclk;

  sarc_alarm_ctrl #(.HS_LIMIT(4), .FILL_WORDS(4)) uut (.pclk, .presetn,
    .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mem_chk, .nvm_rd, .nvm_fix_data, .nvm_fix_valid,
    .rom_scan, .cpu_res, .sensor_alarm_n, .illegal_op, .bus_req, .bus_ack,
    .cipher_chk, .mmu_req, .mmu_deny, .nvm_prog_busy, .nvm_prog_abort,
    .por_req, .rnd_data, .sec_rst, .key_clr, .fill_we, .fill_addr,
    .fill_data, .irq);
  sarc_far_model far (.pclk, .presetn, .cmd, .mem_chk, .nvm_rd, .rom_scan,
    .cpu_res, .cipher_chk, .mmu_req, .sensor_alarm_n, .illegal_op, .bus_req,
    .bus_ack, .nvm_prog_busy, .rnd_data);

  // Remembers short pulses of the programming path
  always @(posedge pclk) begin
    if (nvm_prog_abort) abort_seen <= 1'h1;
    if (por_req) por_seen <= 1'h1;
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    `CHK("pready", 1'h1, pready)
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    apb(1'h0, a, '0);
    `CHK(nm, e, rdv)
  endtask : rd

  task automatic send(input logic [3:0] c);
    @(posedge pclk);
    cmd <= c;
    @(posedge pclk);
    cmd <= '0;
  endtask : send

  task automatic fire(input logic [3:0] c, input int b, input string nm);
    int n;
    n = 0;
    send(c);
    while (sec_rst !== 1'h1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    `CHK(nm, 1'h1, sec_rst)
    while (sec_rst !== 1'h0 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    rd(sarc_pkg::OFF_CAUSE, 32'h1 << b, nm);
    apb(1'h1, sarc_pkg::OFF_STATUS, 32'hfff);
  endtask : fire

  task automatic t_regs;
    rd(sarc_pkg::OFF_MASK, sarc_pkg::MASK_RST, "mask");
    rd(sarc_pkg::OFF_CRIT, sarc_pkg::CRIT_RST, "crit");
    rd(sarc_pkg::OFF_CTRL, sarc_pkg::CTRL_RST, "ctrl");
    rd(sarc_pkg::OFF_MMU_PERM, sarc_pkg::MMU_PERM_RST, "perm");
    rd(sarc_pkg::OFF_WDT_LOAD, sarc_pkg::WDT_LOAD_RST, "load");
    apb(1'h1, sarc_pkg::OFF_CAUSE, 32'hfff);
    rd(sarc_pkg::OFF_CAUSE, '0, "cause ro");
    rd(8'h30, '0, "unmapped");
    `CHK("slverr", 1'h1, errv)
  endtask : t_regs

  task automatic t_alarms;
    logic [3:0] c[7] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'he};
    int b[7] = '{6, 4, 5, 10, 2, 0, 3};
    for (int i = 0; i < 7; i++) begin
      fire(c[i], b[i], "cause");
    end
    fire(4'h8, 6, "prog cause");
    `CHK("abort", 1'h1, abort_seen)
    `CHK("por", 1'h1, por_seen)
  endtask : t_alarms

  task automatic t_irq;
    apb(1'h1, sarc_pkg::OFF_SELFTEST, 32'h1);
    rd(sarc_pkg::OFF_STATUS, 32'h1, "selftest");
    `CHK("no reset", 1'h0, sec_rst)
    `CHK("irq masked", 1'h0, irq)
    apb(1'h1, sarc_pkg::OFF_MASK, 32'hfff);
    repeat (2) @(posedge pclk);
    `CHK("irq on", 1'h1, irq)
    apb(1'h1, sarc_pkg::OFF_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("irq cleared", 1'h0, irq)
    apb(1'h1, sarc_pkg::OFF_MASK, '0);
  endtask : t_irq

  task automatic t_side;
    clk_en <= 1'h0;
    send(4'h4);
    @(posedge pclk);
    clk_en <= 1'h1;
    @(posedge pclk);
    `CHK("frozen", 1'h0, nvm_fix_valid)
    send(4'h4);
    repeat (2) @(posedge pclk);
    `CHK("fix valid", 1'h1, nvm_fix_valid)
    `CHK("fix data", 32'h0000_1334, nvm_fix_data)
    send(4'h5);
    repeat (2) @(posedge pclk);
    `CHK("deny 7", 1'h1, mmu_deny)
    send(4'h6);
    repeat (2) @(posedge pclk);
    `CHK("grant 0", 1'h0, mmu_deny)
    apb(1'h1, sarc_pkg::OFF_MMU_PERM, '0);
    send(4'h6);
    repeat (2) @(posedge pclk);
    `CHK("deny 0", 1'h1, mmu_deny)
    apb(1'h1, sarc_pkg::OFF_STATUS, 32'hfff);
    send(4'hd);
    send(4'hc);
    rd(sarc_pkg::OFF_STATUS, '0, "quiet");
    send(4'h7);
    repeat (12) @(posedge pclk);
    rd(sarc_pkg::OFF_STATUS, 32'h80, "stall");
  endtask : t_side

  task automatic t_flow;
    apb(1'h1, sarc_pkg::OFF_WDT_LOAD, 32'd10);
    apb(1'h1, sarc_pkg::OFF_CTRL, 32'h3);
    apb(1'h1, sarc_pkg::OFF_STATUS, 32'hfff);
    apb(1'h1, sarc_pkg::OFF_WDT_KICK, '0);
    repeat (20) @(posedge pclk);
    apb(1'h1, sarc_pkg::OFF_CTRL, 32'h2);
    rd(sarc_pkg::OFF_STATUS, 32'h100, "watchdog");
    apb(1'h1, sarc_pkg::OFF_STATUS, 32'hfff);
    apb(1'h1, sarc_pkg::OFF_CHKPT, 32'h5);
    apb(1'h1, sarc_pkg::OFF_CHKPT_EXP, 32'h5);
    rd(sarc_pkg::OFF_STATUS, '0, "flow ok");
    apb(1'h1, sarc_pkg::OFF_CHKPT_EXP, 32'h5);
    rd(sarc_pkg::OFF_STATUS, 32'h200, "flow bad");
  endtask : t_flow

  task automatic results;
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_alarms();
    t_irq();
    t_side();
    t_flow();
    results();
  end

  // Cuts a hang short
  initial begin
    #200000;
    mismatches++;
    results();
  end
endmodule : sarc_alarm_ctrl_test
